// ===== include/epe_pkg.sv
// constants and types of the exception priority, entry and return unit
// assumes one core clock domain and a synchronous active-low reset
// Behaviour
// [RQ1] a smaller priority value is the more urgent one
// [RQ2] every programmable priority reads zero after reset
// [RQ3] programmable priorities span 0-15; fixed ones always outrank them
// [RQ4] equal priority: smallest exception number is serviced first
// [RQ5] equal priority never preempts the running handler; it stays pending
// [RQ6] priority splits into group and subpriority; only group preempts
// [RQ7] equal group: order by subpriority, then lowest number
// [RQ8] completion with nothing to take unstacks and restores state
// [RQ9] completion with a qualifying pending exception tail-chains, no unstack
// [RQ10] more urgent arrival during stacking switches vector, stacking continues
// [RQ11] late arrival accepted until the first handler instruction executes
// [RQ12] entry from thread mode, or nested when outranking the active one
// [RQ13] exceptions not above the mask limit stay pending and untaken
// [RQ14] normal entry pushes an eight-word frame on the current stack
// [RQ15] stack pointer ends at frame base; alignment to double word if enabled
// [RQ16] stacked return address is reloaded into the pc on return
// [RQ17] vector fetch runs beside stacking; handler starts with return code
// [RQ18] handler start moves pending to active; late arrival leaves earlier pending
// [RQ19] return starts on a handler-mode pop, branch exchange or load to pc
// [RQ20] return code bits 31:4 are all ones and mark the return
// [RQ21] low nibble 1, 9, 13 select handler/main, thread/main, thread/process
// [RQ22] non-maskable interrupt has fixed priority -2, below only reset
// [RQ23] hard fault has fixed priority -1, above every programmable one
// [RQ24] a reserved return nibble raises a usage fault instead
package epe_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_PEND_SET = 8'h08;
    localparam logic [7:0] OFS_PEND_CLR = 8'h0c;
    localparam logic [7:0] OFS_ACTIVE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_PRIO = 8'h20;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam logic [3:0] PRIO_RESET = 4'h0;
    localparam int CTRL_ALIGN_BIT = 0;
    localparam int CTRL_SUB_LSB = 4;
    localparam int MASK_EN_BIT = 4;
    localparam logic [31:0] SYS_VALID = 32'h0000_c87c;
    localparam logic [4:0] EXC_NMI = 5'h02;
    localparam logic [4:0] EXC_HARD = 5'h03;
    localparam logic [4:0] EXC_USAGE = 5'h06;
    localparam logic [4:0] KEY_NMI = 5'h00;
    localparam logic [4:0] KEY_HARD = 5'h01;
    localparam logic [4:0] KEY_OFS = 5'h02;
    localparam logic [4:0] KEY_NONE = 5'h1f;
    localparam logic [27:0] RET_PREFIX = 28'hfffffff;
    localparam logic [3:0] RET_HANDLER = 4'h1;
    localparam logic [3:0] RET_THREAD_MAIN = 4'h9;
    localparam logic [3:0] RET_THREAD_PROC = 4'hd;
    localparam logic [3:0] FRAME_WORDS = 4'h8;
    localparam logic [31:0] FRAME_BYTES = 32'h0000_0020;
    localparam logic [31:0] PAD_BYTES = 32'h0000_0004;
    localparam logic [2:0] WORD_RET_ADDR = 3'h6;
    localparam logic [2:0] WORD_PSR = 3'h7;
    localparam int PSR_PAD_BIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_STACK = 6'b000010,
        ST_START = 6'b000100,
        ST_TAIL = 6'b001000,
        ST_RET = 6'b010000,
        ST_UNSTACK = 6'b100000
    } epe_state_t;
endpackage

// ===== src/epe_exception_unit.sv
// exception arbitration, entry stacking, vector fetch and return sequencing
// assumes request inputs and core handshakes are on sys_clk; core moves the frame data
`timescale 1ns/1ps
module epe_exception_unit
    import epe_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter logic [31:0] VECTOR_BASE = 32'h0000_0000
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15+NUM_IRQ:0] exc_req,
    input wire logic [31:0] main_stack_pointer,
    input wire logic [31:0] process_stack_pointer,
    input wire logic thread_uses_psp,
    output logic push_valid,
    input wire logic push_ready,
    output logic [31:0] push_addr,
    output logic [2:0] push_sel,
    output logic frame_padded,
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [31:0] pop_addr,
    input wire logic [31:0] pop_data,
    output logic vec_valid,
    input wire logic vec_ready,
    output logic [31:0] vec_addr,
    input wire logic [31:0] vec_data,
    output logic handler_go,
    output logic [31:0] handler_pc,
    output logic [31:0] link_register,
    output logic [4:0] handler_exc,
    input wire logic first_exec,
    input wire logic pc_load_valid,
    input wire logic [1:0] pc_load_src,
    input wire logic [31:0] pc_load_value,
    output logic sp_update,
    output logic sp_update_psp,
    output logic [31:0] sp_update_value,
    output logic resume_go,
    output logic [31:0] resume_pc,
    output logic handler_mode
);
    localparam int NE = 16 + NUM_IRQ;
    localparam logic [31:0] EXC_VALID = (SYS_VALID | 32'hffff_0000) & 32'((64'h1 << NE) - 64'h1);

    epe_state_t state;
    logic [3:0] prio [NE];
    logic [31:0] ctrl;
    logic [4:0] mask;
    logic [31:0] pend;
    logic [31:0] active;
    logic [4:0] sel_exc;
    logic late_flag;
    logic [3:0] word_cnt;
    logic vec_done;
    logic [31:0] frame_base;
    logic frame_psp;
    logic pop_pad;
    logic [31:0] ret_code;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_err;
    logic wr_err;
    logic wr_fire;
    logic rd_fire;
    logic [4:0] best;
    logic [4:0] widx;
    logic wval;
    logic [4:0] w_grp;
    logic [4:0] exec_pri;
    logic [4:0] cur_exc;
    logic [4:0] cur_best;
    logic [4:0] sel_grp;
    logic suff;
    logic take_ok;
    logic late_ok;
    logic commit;
    logic ret_seen;
    logic ret_hit;
    logic ret_bad;
    logic [31:0] set_mask;
    logic [31:0] clr_mask;
    logic [31:0] entry_sp;
    logic [31:0] raw_base;
    logic [3:0] sub_bits;

    // urgency key: fixed exceptions lowest, programmable value offset above them
    function automatic logic [4:0] fn_key(input logic [4:0] e, input logic [3:0] p,
                                          input logic [3:0] sb, input logic grp);
        logic [3:0] v;
        v = grp ? (p & 4'(4'hf << sb)) : p; // RQ6
        if (e == EXC_NMI) begin
            fn_key = KEY_NMI; // RQ22
        end else if (e == EXC_HARD) begin
            fn_key = KEY_HARD; // RQ23
        end else begin
            fn_key = {1'b0, v} + KEY_OFS; // RQ3
        end
    endfunction

    function automatic logic [31:0] fn_bytes(input logic [3:0] s);
        fn_bytes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    assign sub_bits = (ctrl[CTRL_SUB_LSB+2:CTRL_SUB_LSB] > 3'h4) ? 4'h4
                      : {1'b0, ctrl[CTRL_SUB_LSB+2:CTRL_SUB_LSB]};

    // pending winner
    always_comb begin
        best = KEY_NONE;
        widx = 5'h00;
        wval = 1'b0;
        for (int i = NE - 1; i >= 0; i--) begin
            if (pend[i] && EXC_VALID[i] && fn_key(5'(i), prio[i], sub_bits, 1'b0) <= best) begin
                best = fn_key(5'(i), prio[i], sub_bits, 1'b0); // RQ1 RQ4 RQ7
                widx = 5'(i);
                wval = 1'b1;
            end
        end
    end

    // running priority and running exception
    always_comb begin
        exec_pri = KEY_NONE;
        cur_best = KEY_NONE;
        cur_exc = 5'h00;
        for (int i = NE - 1; i >= 0; i--) begin
            if (active[i] && fn_key(5'(i), prio[i], sub_bits, 1'b1) <= exec_pri) begin
                exec_pri = fn_key(5'(i), prio[i], sub_bits, 1'b1);
            end
            if (active[i] && fn_key(5'(i), prio[i], sub_bits, 1'b0) <= cur_best) begin
                cur_best = fn_key(5'(i), prio[i], sub_bits, 1'b0);
                cur_exc = 5'(i);
            end
        end
    end

    assign w_grp = fn_key(widx, prio[widx], sub_bits, 1'b1);
    assign sel_grp = fn_key(sel_exc, prio[sel_exc], sub_bits, 1'b1);
    assign suff = (widx == EXC_NMI) || (widx == EXC_HARD) || !mask[MASK_EN_BIT]
                  || (w_grp < ({1'b0, mask[3:0]} + KEY_OFS)); // RQ13
    assign take_ok = wval && suff && (w_grp < exec_pri); // RQ5 RQ12
    assign late_ok = wval && suff && (w_grp < sel_grp) && (widx != sel_exc); // RQ10
    assign commit = (state == ST_START) && first_exec;
    assign ret_seen = (state == ST_IDLE) && handler_mode && pc_load_valid
                      && (pc_load_src != 2'b00) && (pc_load_value[31:4] == RET_PREFIX); // RQ19 RQ20
    assign ret_hit = ret_seen && ((pc_load_value[3:0] == RET_HANDLER)
                     || (pc_load_value[3:0] == RET_THREAD_MAIN)
                     || (pc_load_value[3:0] == RET_THREAD_PROC)); // RQ21
    assign ret_bad = ret_seen && !ret_hit; // RQ24

    assign entry_sp = (handler_mode || !thread_uses_psp) ? main_stack_pointer
                      : process_stack_pointer;
    assign raw_base = entry_sp - FRAME_BYTES;

    assign push_valid = (state == ST_STACK) && (word_cnt < FRAME_WORDS);
    assign push_sel = word_cnt[2:0];
    assign push_addr = frame_base + {27'h0, word_cnt[2:0], 2'b00};
    assign pop_valid = (state == ST_UNSTACK) && (word_cnt < FRAME_WORDS);
    assign pop_addr = frame_base + {27'h0, word_cnt[2:0], 2'b00};
    assign vec_addr = VECTOR_BASE + {25'h0, sel_exc, 2'b00};
    assign link_register = ret_code;
    assign handler_exc = sel_exc;

    // pending and active state; a set wins over any clear in the same cycle
    always_comb begin
        set_mask = (32'(exc_req) & EXC_VALID)
                   | ({32{ret_bad}} & (32'h1 << EXC_USAGE)); // RQ24
        clr_mask = {32{commit}} & (32'h1 << sel_exc); // RQ18
        if (wr_fire && !wr_err && s_axi_awaddr[7:0] == OFS_PEND_SET) begin
            set_mask = set_mask | (s_axi_wdata & wmask & EXC_VALID);
        end
        if (wr_fire && !wr_err && s_axi_awaddr[7:0] == OFS_PEND_CLR) begin
            clr_mask = clr_mask | (s_axi_wdata & wmask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pend <= 32'h0;
        end else begin
            pend <= (pend & ~clr_mask) | set_mask; // RQ5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active <= 32'h0;
        end else if (commit) begin
            active <= active | (32'h1 << sel_exc); // RQ18
        end else if (ret_hit) begin
            active <= active & ~(32'h1 << cur_exc);
        end
    end

    // entry and return sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            sel_exc <= 5'h00;
            late_flag <= 1'b0;
            word_cnt <= 4'h0;
            vec_valid <= 1'b0;
            vec_done <= 1'b0;
            handler_pc <= 32'h0;
            frame_base <= 32'h0;
            frame_psp <= 1'b0;
            frame_padded <= 1'b0;
            pop_pad <= 1'b0;
            ret_code <= 32'h0;
            handler_go <= 1'b0;
            handler_mode <= 1'b0;
            sp_update <= 1'b0;
            sp_update_psp <= 1'b0;
            sp_update_value <= 32'h0;
            resume_go <= 1'b0;
            resume_pc <= 32'h0;
        end else begin
            handler_go <= 1'b0;
            sp_update <= 1'b0;
            resume_go <= 1'b0;
            if (vec_valid && vec_ready) begin
                vec_valid <= 1'b0;
                vec_done <= 1'b1;
                handler_pc <= vec_data; // RQ17
            end
            unique case (state)
                ST_IDLE: begin
                    if (ret_hit) begin
                        ret_code <= pc_load_value;
                        state <= ST_RET;
                    end else if (take_ok && !ret_bad) begin
                        sel_exc <= widx; // RQ12
                        late_flag <= 1'b0;
                        word_cnt <= 4'h0;
                        vec_valid <= 1'b1;
                        vec_done <= 1'b0;
                        frame_psp <= !handler_mode && thread_uses_psp;
                        frame_padded <= ctrl[CTRL_ALIGN_BIT] && raw_base[2]; // RQ15
                        frame_base <= ctrl[CTRL_ALIGN_BIT] ? {raw_base[31:3], 3'b000}
                                      : raw_base; // RQ15
                        ret_code <= {RET_PREFIX, handler_mode ? RET_HANDLER
                                     : (thread_uses_psp ? RET_THREAD_PROC
                                     : RET_THREAD_MAIN)}; // RQ20
                        state <= ST_STACK; // RQ14
                    end
                end
                ST_STACK: begin
                    if (push_valid && push_ready) begin
                        word_cnt <= word_cnt + 4'h1; // RQ14
                    end
                    if (late_ok) begin
                        sel_exc <= widx; // RQ10
                        late_flag <= 1'b1;
                        vec_valid <= 1'b1;
                        vec_done <= 1'b0;
                    end else if (word_cnt == FRAME_WORDS && vec_done) begin
                        sp_update <= 1'b1;
                        sp_update_psp <= frame_psp;
                        sp_update_value <= frame_base; // RQ15
                        handler_go <= 1'b1; // RQ17
                        handler_mode <= 1'b1;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (first_exec) begin
                        state <= ST_IDLE; // RQ11
                    end else if (late_ok) begin
                        sel_exc <= widx; // RQ11
                        late_flag <= 1'b1;
                        vec_valid <= 1'b1;
                        vec_done <= 1'b0;
                        state <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    if (late_ok) begin
                        sel_exc <= widx;
                        vec_valid <= 1'b1;
                        vec_done <= 1'b0;
                    end else if (vec_done) begin
                        handler_go <= 1'b1; // RQ9
                        handler_mode <= 1'b1;
                        state <= ST_START;
                    end
                end
                ST_RET: begin
                    if (take_ok) begin
                        sel_exc <= widx; // RQ9
                        late_flag <= 1'b0;
                        vec_valid <= 1'b1;
                        vec_done <= 1'b0;
                        state <= ST_TAIL;
                    end else begin
                        frame_psp <= ret_code[3:0] == RET_THREAD_PROC; // RQ21
                        frame_base <= (ret_code[3:0] == RET_THREAD_PROC)
                                      ? process_stack_pointer : main_stack_pointer;
                        word_cnt <= 4'h0;
                        state <= ST_UNSTACK; // RQ8
                    end
                end
                ST_UNSTACK: begin
                    if (pop_valid && pop_ready) begin
                        word_cnt <= word_cnt + 4'h1;
                        if (word_cnt[2:0] == WORD_RET_ADDR) begin
                            resume_pc <= pop_data; // RQ16
                        end
                        if (word_cnt[2:0] == WORD_PSR) begin
                            pop_pad <= pop_data[PSR_PAD_BIT];
                        end
                    end
                    if (word_cnt == FRAME_WORDS) begin
                        sp_update <= 1'b1;
                        sp_update_psp <= frame_psp;
                        sp_update_value <= frame_base + FRAME_BYTES
                                           + (pop_pad ? PAD_BYTES : 32'h0); // RQ15
                        resume_go <= 1'b1; // RQ8
                        handler_mode <= ret_code[3:0] == RET_HANDLER; // RQ21
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // register bus
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign s_axi_arready = !s_axi_rvalid;
    assign wmask = fn_bytes(s_axi_wstrb);

    always_comb begin
        wr_err = 1'b1;
        if (s_axi_awaddr[31:8] == 24'h0 && s_axi_awaddr[1:0] == 2'b00) begin
            wr_err = !(s_axi_awaddr[7:0] == OFS_CTRL || s_axi_awaddr[7:0] == OFS_MASK
                     || s_axi_awaddr[7:0] == OFS_PEND_SET || s_axi_awaddr[7:0] == OFS_PEND_CLR
                     || s_axi_awaddr[7:0] == OFS_ACTIVE || s_axi_awaddr[7:0] == OFS_STATUS
                     || (s_axi_awaddr[7:4] == OFS_PRIO[7:4] && s_axi_awaddr[3:2] <= 2'(NE/8 - 1)));
        end
    end

    always_comb begin
        rd_err = 1'b0;
        rd_word = 32'h0;
        if (s_axi_araddr[31:8] != 24'h0 || s_axi_araddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end else if (s_axi_araddr[7:4] == OFS_PRIO[7:4]) begin
            for (int i = 0; i < NE; i++) begin
                if (i / 8 == int'(s_axi_araddr[3:2]) && EXC_VALID[i]
                    && i != int'(EXC_NMI) && i != int'(EXC_HARD)) begin
                    rd_word[(i % 8) * 4 +: 4] = prio[i];
                end
            end
            rd_err = s_axi_araddr[3:2] > 2'(NE/8 - 1);
        end else begin
            unique case (s_axi_araddr[7:0])
                OFS_CTRL: rd_word = ctrl;
                OFS_MASK: rd_word = {27'h0, mask};
                OFS_PEND_SET: rd_word = pend;
                OFS_PEND_CLR: rd_word = pend;
                OFS_ACTIVE: rd_word = active;
                OFS_STATUS: rd_word = {16'h0, handler_mode, late_flag, state, 3'h0, sel_exc};
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            mask <= MASK_RESET;
        end else if (wr_fire && !wr_err) begin
            if (s_axi_awaddr[7:0] == OFS_CTRL) begin
                ctrl <= ((ctrl & ~wmask) | (s_axi_wdata & wmask)) & 32'h0000_0071;
            end
            if (s_axi_awaddr[7:0] == OFS_MASK && s_axi_wstrb[0]) begin
                mask <= s_axi_wdata[4:0]; // RQ13
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NE; i++) begin
                prio[i] <= PRIO_RESET; // RQ2
            end
        end else if (wr_fire && !wr_err && s_axi_awaddr[7:4] == OFS_PRIO[7:4]) begin
            for (int i = 0; i < NE; i++) begin
                if (i / 8 == int'(s_axi_awaddr[3:2]) && s_axi_wstrb[(i % 8) / 2]) begin
                    prio[i] <= s_axi_wdata[(i % 8) * 4 +: 4]; // RQ3
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            s_axi_rdata <= rd_err ? 32'h0 : rd_word;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // epe_exception_unit

// ===== bench/epe_unit_sva.sv
// checker of frame pushes, return code and return timing
// bound into every epe_exception_unit; one clock domain
`timescale 1ns/1ps
module epe_unit_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic push_valid,
    input wire logic push_ready,
    input wire logic handler_go,
    input wire logic [31:0] link_register,
    input wire logic sp_update,
    input wire logic [31:0] sp_update_value,
    input wire logic resume_go,
    input wire logic handler_mode,
    input wire logic pc_load_valid,
    input wire logic [1:0] pc_load_src,
    input wire logic [31:0] pc_load_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] pushes;
    wire ret_ld = pc_load_valid && pc_load_src != 2'h0 && handler_mode && !push_valid
        && pc_load_value[31:4] == 28'hfffffff;
    wire ok_nib = pc_load_value[3:0] inside {4'h1, 4'h9, 4'hd};
    always_ff @(posedge sys_clk)
        if (!rst_n || handler_go) pushes <= 4'h0;
        else if (push_valid && push_ready) pushes <= pushes + 4'h1;
    chk_frame_words: assert property (handler_go |-> pushes == (sp_update ? 4'h8 : 4'h0))
        else $error("bad frame count");
    chk_ret_prefix: assert property (handler_go |-> link_register[31:4] == 28'hfffffff)
        else $error("bad code prefix");
    chk_ret_mode: assert property (handler_go |-> link_register[3:0] inside {4'h1, 4'h9, 4'hd})
        else $error("bad code mode");
    chk_frame_align: assert property (handler_go && sp_update |-> sp_update_value[2:0] == 3'h0)
        else $error("frame not aligned");
    chk_go_pulse: assert property (handler_go |=> $fell(handler_go))
        else $error("start not a pulse");
    chk_go_mode: assert property (handler_go |-> ##1 handler_mode)
        else $error("no handler mode");
    chk_ret_done: assert property (ret_ld && ok_nib |-> ##[1:200] (resume_go || handler_go))
        else $error("return not done");
    chk_ret_bad: assert property (ret_ld && !ok_nib |=> !resume_go [*8])
        else $error("reserved code returned");
endmodule // epe_unit_sva

bind epe_exception_unit epe_unit_sva i_sva (.sys_clk, .rst_n, .push_valid, .push_ready,
    .handler_go, .link_register, .sp_update, .sp_update_value, .resume_go, .handler_mode,
    .pc_load_valid, .pc_load_src, .pc_load_value);

// ===== bench/epe_core_model.sv
// core side model: frame pushes, frame pops, vector reads, main stack pointer
// answers at once, or every other cycle while slow is high
`timescale 1ns/1ps
module epe_core_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic push_valid,
    output logic push_ready,
    input wire logic pop_valid,
    input wire logic [31:0] pop_addr,
    output logic pop_ready,
    output logic [31:0] pop_data,
    input wire logic vec_valid,
    input wire logic [31:0] vec_addr,
    output logic vec_ready,
    output logic [31:0] vec_data,
    input wire logic sp_update,
    input wire logic [31:0] sp_update_value,
    output logic [31:0] main_stack_pointer
);
    logic tick;
    always_ff @(posedge sys_clk) tick <= rst_n && !tick;
    always_ff @(posedge sys_clk)
        if (!rst_n) main_stack_pointer <= 32'h0000_1000;
        else if (sp_update) main_stack_pointer <= sp_update_value;
    assign {push_ready, pop_ready, vec_ready} =
        {push_valid, pop_valid, vec_valid} & {3{!slow || tick}};
    // word 6 holds the return address; unanswered data lines carry junk
    assign pop_data = !pop_ready ? ~pop_addr : pop_addr[4:2] == 3'h6 ? 32'h0000_1234 : 32'h0;
    assign vec_data = vec_ready ? vec_addr + 32'h1 : ~vec_addr;
endmodule // epe_core_model

// ===== bench/test_exception_priority_entry_return.sv
// register, entry, tail-chain, mask and return tests of the exception unit
// epe_core_model answers the core side; main stack only
`timescale 1ns/1ps
module test_exception_priority_entry_return;
    localparam logic [31:0] RT = 32'hffff_fff9;
    logic sys_clk = 1'b0, rst_n = 1'b0, first_exec = 1'b0, pc_load_valid = 1'b0, slow = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, thread_uses_psp = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [31:0] pc_load_value = 32'h0, process_stack_pointer = 32'h0000_2000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] pc_load_src = 2'h1;
    logic [23:0] exc_req = 24'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, push_valid;
    logic push_ready, pop_valid, pop_ready, vec_valid, vec_ready, handler_go, frame_padded;
    logic sp_update, sp_update_psp, resume_go, handler_mode;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] push_sel;
    logic [4:0] handler_exc;
    logic [31:0] s_axi_rdata, push_addr, pop_addr, pop_data, vec_addr, vec_data, handler_pc;
    logic [31:0] link_register, sp_update_value, resume_pc, main_stack_pointer;
    int miscompares = 0, n_tests = 0;
    always #2 sys_clk = ~sys_clk;
    epe_exception_unit i_dut (.*);
    epe_core_model i_core (.*);
    task automatic chk(input string n, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, e);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        do @(posedge sys_clk); while (!(w ? s_axi_awready : s_axi_arready));
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        do @(posedge sys_clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
        chk("axi", e, w ? {30'h0, s_axi_bresp} : {s_axi_rresp, s_axi_rdata[29:0]});
    endtask
    task automatic step(input logic [23:0] req, input logic [31:0] v, e, lr, sp);
        logic [31:0] g;
        {exc_req, pc_load_value, pc_load_valid} <= {req, v, v != 32'h0};
        pc_load_src <= pc_load_src % 2'h3 + 2'h1;
        @(posedge sys_clk);
        {exc_req, pc_load_valid} <= 25'h0;
        do @(posedge sys_clk); while (!handler_go && !resume_go);
        g = handler_go ? handler_pc : resume_pc;
        chk("number", e, handler_go ? {27'h0, handler_exc} : 32'h0);
        chk("pc", e != 32'h0 ? {e[29:0], 2'h1} : 32'h0000_1234, g);
        chk("lr", lr, link_register);
        chk("sp", sp, sp_update ? sp_update_value : 32'h0);
        chk("flags", 32'h0, {30'h0, frame_padded, sp_update_psp});
        first_exec <= handler_go;
        @(posedge sys_clk);
        first_exec <= 1'b0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        bus(1'b0, 32'h28, 32'h0, 32'h0);
        bus(1'b0, 32'h0, 32'h0, 32'h1);
        bus(1'b0, 32'h80, 32'h0, 32'h8000_0000);
        bus(1'b1, 32'h28, 32'h12, 32'h0);
        step(24'h03_0000, 32'h0, 32'h11, RT, 32'hfe0);
        step(24'h0, RT, 32'h10, RT, 32'h0);
        step(24'h0, RT, 32'h0, RT, 32'h1000);
        slow <= 1'b1;
        bus(1'b1, 32'h04, 32'h11, 32'h0);
        step(24'h01_0004, 32'h0, 32'h2, RT, 32'hfe0);
        step(24'h0, RT, 32'h0, RT, 32'h1000);
        bus(1'b0, 32'h08, 32'h0, 32'h0001_0000);
        bus(1'b1, 32'h04, 32'h0, 32'h0);
        step(24'h0, 32'h0, 32'h10, RT, 32'hfe0);
        step(24'h0, 32'hffff_fff5, 32'h6, 32'hffff_fff1, 32'hfc0);
        finish_test;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        finish_test;
    end
endmodule // test_exception_priority_entry_return
